// ==== dyn_pkg.sv ====
// Package of constants and types for the picking dynamics channel mixer.
package dyn_pkg;
    localparam int LEVEL_W = 7;
    localparam int SAMPLE_W = 16;
    localparam int GAIN_W = 7;
    localparam logic [6:0] LEVEL_MAX = 7'h64;
    localparam logic [6:0] THR_LOW_MAX = 7'h63;
    localparam logic [6:0] THR_HIGH_MIN = 7'h01;
    localparam logic [6:0] RESET_LEVEL = 7'h64;
    localparam logic [6:0] RESET_BALANCE = 7'h32;
    localparam logic [6:0] RESET_PEAK = 7'h00;
    localparam int ONSET_RATIO_SHIFT = 1;
    localparam int HOLD_TIME_US = 20000;
    localparam int CLK_MHZ = 40;
    localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;
    localparam int RELEASE_BASE_CYCLES = 64;
    localparam int SMOOTH_SHIFT = 3;
    localparam int SMOOTH_CYCLES = 16;
    typedef enum logic [1:0] {
        MODE_CHAN_A,
        MODE_CHAN_B,
        MODE_BALANCE
    } dyn_mode_type;
endpackage

// ==== dyn_ctrl_if.sv ====
// Interface carrying the held picking level between detector and mapper.
`timescale 1ns/10ps
`default_nettype none
interface dyn_ctrl_if;
    import dyn_pkg::*;
    logic [LEVEL_W-1:0] held_level;
    logic new_pick;
    modport src (output held_level, output new_pick);
    modport dst (input held_level, input new_pick);
endinterface
`default_nettype wire

// ==== pick_detector.sv ====
// Note onset detector with peak capture, hold and release decay.
`timescale 1ns/10ps
`default_nettype none
module pick_detector #(
    parameter int HOLD_CYC = dyn_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_valid,
    input wire logic [dyn_pkg::LEVEL_W-1:0] input_level,
    input wire logic [dyn_pkg::LEVEL_W-1:0] release_rate,
    dyn_ctrl_if.src ctrl
);
    import dyn_pkg::*;

    typedef struct packed {
        logic [LEVEL_W-1:0] peak;
        logic [LEVEL_W-1:0] prev;
        logic [31:0] hold_cnt;
        logic [15:0] rel_cnt;
        logic pick;
    } det_state_type;

    det_state_type st_r;
    det_state_type st_nxt;
    logic [15:0] rel_period;

    // Higher release setting decays faster; zero gives the slowest decay.
    assign rel_period = 16'(RELEASE_BASE_CYCLES) *
        16'(LEVEL_MAX - release_rate + 7'h01);

    // A rise above the held level and half again above the previous level marks a fresh pick.
    always_comb begin
        st_nxt = st_r;
        st_nxt.pick = 1'b0;
        if (sample_valid) begin
            st_nxt.prev = input_level;
            // One extra bit, since a loud previous level plus half passes 127.
            if (input_level > st_r.peak &&
                    {1'b0, input_level} > {1'b0, st_r.prev} +
                    8'(st_r.prev >> ONSET_RATIO_SHIFT)) begin
                st_nxt.peak = input_level;
                st_nxt.hold_cnt = 32'(HOLD_CYC);
                st_nxt.pick = 1'b1;
            end
        end
        if (!st_nxt.pick) begin
            if (st_r.hold_cnt != 32'h0) begin
                st_nxt.hold_cnt = st_r.hold_cnt - 32'h1;
                st_nxt.rel_cnt = 16'h0;
            end else if (st_r.peak > input_level) begin
                // Decay only toward the live level, never below it.
                // Counting 0 to period-1 gives exactly one step per period.
                if (st_r.rel_cnt >= rel_period - 16'h1) begin
                    st_nxt.rel_cnt = 16'h0;
                    st_nxt.peak = st_r.peak - 7'h01;
                end else begin
                    st_nxt.rel_cnt = st_r.rel_cnt + 16'h1;
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ctrl.held_level = st_r.peak;
    assign ctrl.new_pick = st_r.pick;
endmodule
`default_nettype wire

// ==== dyn_gain_map.sv ====
// Maps held level through the threshold curve with linear interpolation.
`timescale 1ns/10ps
`default_nettype none
module dyn_gain_map (
    input wire logic clk,
    input wire logic sys_rst,
    dyn_ctrl_if.dst ctrl,
    input wire logic [dyn_pkg::LEVEL_W-1:0] low_threshold,
    input wire logic [dyn_pkg::LEVEL_W-1:0] high_threshold,
    input wire logic [dyn_pkg::LEVEL_W-1:0] soft_value,
    input wire logic [dyn_pkg::LEVEL_W-1:0] loud_value,
    output logic [dyn_pkg::LEVEL_W-1:0] target_r
);
    import dyn_pkg::*;

    typedef struct packed {
        logic [LEVEL_W-1:0] target;
    } map_state_type;

    map_state_type st_r;
    map_state_type st_nxt;
    logic [LEVEL_W-1:0] lo;
    logic [LEVEL_W-1:0] hi;
    logic signed [15:0] span;
    logic signed [15:0] pos;
    logic signed [15:0] diff;
    logic signed [15:0] interp;

    // Clamp thresholds to their ranges; a crossed pair acts as a step.
    assign lo = (low_threshold > THR_LOW_MAX) ? THR_LOW_MAX : low_threshold;
    assign hi = (high_threshold > LEVEL_MAX) ? LEVEL_MAX :
        (high_threshold < THR_HIGH_MIN) ? THR_HIGH_MIN : high_threshold;
    assign span = 16'(hi) - 16'(lo);
    assign pos = 16'(ctrl.held_level) - 16'(lo);
    assign diff = 16'(loud_value) - 16'(soft_value);

    // Interpolation divides by the span; a small divider is fine at 40 MHz.
    always_comb begin
        st_nxt = st_r;
        interp = 16'(soft_value);
        if (ctrl.held_level <= lo) begin
            st_nxt.target = soft_value;
        end else if (ctrl.held_level >= hi) begin
            st_nxt.target = loud_value;
        end else begin
            interp = 16'(soft_value) + 16'((diff * pos) / span);
            st_nxt.target = interp[LEVEL_W-1:0];
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign target_r = st_r.target;
endmodule
`default_nettype wire

// ==== picking_dynamics_channel_mixer.sv ====
// Top of the picking dynamics controlled two-channel mixer gain stage.
// What this block does
// - Dynamics on overrides static A/B balance
// - Off/on switch enables or bypasses dynamics
// - Type A modulates A, holds B
// - Type B modulates B, holds A
// - Balance type moves both channels together
// - Soft level 0 to 100 accepted
// - Soft balance 0:100 to 100:0 accepted
// - Loud level 0 to 100 accepted
// - Loud balance 0:100 to 100:0 accepted
// - Level settings single-channel only; balance in balance
// - At or below low threshold: soft value
// - At or above high threshold: loud value
// - Between thresholds vary continuously
// - Capture and hold peak at note onset
// - Release sets falling response speed
// - Re-evaluate at every new pick
`timescale 1ns/10ps
`default_nettype none
module picking_dynamics_channel_mixer #(
    parameter int HOLD_CYC = dyn_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_valid,
    input wire logic [dyn_pkg::LEVEL_W-1:0] input_level,
    input wire logic signed [dyn_pkg::SAMPLE_W-1:0] chan_a_in,
    input wire logic signed [dyn_pkg::SAMPLE_W-1:0] chan_b_in,
    input wire logic dyn_enable,
    input wire dyn_pkg::dyn_mode_type dyn_type,
    input wire logic [dyn_pkg::LEVEL_W-1:0] static_chan_balance,
    input wire logic [dyn_pkg::LEVEL_W-1:0] chan_a_volume,
    input wire logic [dyn_pkg::LEVEL_W-1:0] chan_b_volume,
    input wire logic [dyn_pkg::LEVEL_W-1:0] soft_level,
    input wire logic [dyn_pkg::LEVEL_W-1:0] soft_balance,
    input wire logic [dyn_pkg::LEVEL_W-1:0] loud_level,
    input wire logic [dyn_pkg::LEVEL_W-1:0] loud_balance,
    input wire logic [dyn_pkg::LEVEL_W-1:0] low_threshold,
    input wire logic [dyn_pkg::LEVEL_W-1:0] high_threshold,
    input wire logic [dyn_pkg::LEVEL_W-1:0] release_rate,
    output logic signed [dyn_pkg::SAMPLE_W-1:0] mix_out,
    output logic mix_valid,
    output logic [dyn_pkg::LEVEL_W-1:0] gain_a_out,
    output logic [dyn_pkg::LEVEL_W-1:0] gain_b_out,
    output logic [dyn_pkg::LEVEL_W-1:0] held_level_out,
    output logic new_pick_out
);
    import dyn_pkg::*;

    typedef struct packed {
        logic [LEVEL_W-1:0] gain_a;
        logic [LEVEL_W-1:0] gain_b;
        logic [LEVEL_W-1:0] goal_a;
        logic [LEVEL_W-1:0] goal_b;
        logic [4:0] smooth_cnt;
        logic signed [SAMPLE_W-1:0] mix;
        logic mix_vld;
    } top_state_type;

    top_state_type st_r;
    top_state_type st_nxt;
    dyn_ctrl_if ctrl_bus ();
    logic [LEVEL_W-1:0] soft_sel;
    logic [LEVEL_W-1:0] loud_sel;
    logic [LEVEL_W-1:0] target;
    logic signed [31:0] prod_a;
    logic signed [31:0] prod_b;
    logic signed [31:0] sum_ab;

    // Clamp a setting to the 0..100 scale.
    function automatic logic [LEVEL_W-1:0] clamp100(
        input logic [LEVEL_W-1:0] v
    );
        return (v > LEVEL_MAX) ? LEVEL_MAX : v;
    endfunction

    // Step a gain one unit toward its goal, the smoothing primitive.
    function automatic logic [LEVEL_W-1:0] step_to(
        input logic [LEVEL_W-1:0] cur,
        input logic [LEVEL_W-1:0] goal
    );
        if (cur < goal) begin
            return cur + 7'h01;
        end else if (cur > goal) begin
            return cur - 7'h01;
        end
        return cur;
    endfunction

    pick_detector #(
        .HOLD_CYC(HOLD_CYC)
    ) u_det (
        .clk(clk),
        .sys_rst(sys_rst),
        .sample_valid(sample_valid),
        .input_level(input_level),
        .release_rate(clamp100(release_rate)),
        .ctrl(ctrl_bus)
    );

    // Only the settings that match the type feed the curve.
    always_comb begin
        if (dyn_type == MODE_BALANCE) begin
            soft_sel = clamp100(soft_balance);
            loud_sel = clamp100(loud_balance);
        end else begin
            soft_sel = clamp100(soft_level);
            loud_sel = clamp100(loud_level);
        end
    end

    dyn_gain_map u_map (
        .clk(clk),
        .sys_rst(sys_rst),
        .ctrl(ctrl_bus),
        .low_threshold(low_threshold),
        .high_threshold(high_threshold),
        .soft_value(soft_sel),
        .loud_value(loud_sel),
        .target_r(target)
    );

    // Goals per channel; balance value counts toward channel B.
    always_comb begin
        st_nxt = st_r;
        st_nxt.mix_vld = sample_valid;
        if (!dyn_enable) begin
            // Bypass: static balance and channel volumes rule.
            st_nxt.goal_a = 7'(({7'h0, clamp100(chan_a_volume)} *
                {7'h0, LEVEL_MAX - clamp100(static_chan_balance)})
                / 14'(LEVEL_MAX));
            st_nxt.goal_b = 7'(({7'h0, clamp100(chan_b_volume)} *
                {7'h0, clamp100(static_chan_balance)}) / 14'(LEVEL_MAX));
        end else begin
            case (dyn_type)
                MODE_CHAN_A: begin
                    st_nxt.goal_a = target;
                    st_nxt.goal_b = clamp100(chan_b_volume);
                end
                MODE_CHAN_B: begin
                    st_nxt.goal_a = clamp100(chan_a_volume);
                    st_nxt.goal_b = target;
                end
                default: begin
                    st_nxt.goal_a = LEVEL_MAX - target;
                    st_nxt.goal_b = target;
                end
            endcase
        end
        // Gains walk toward goals at a limited rate to avoid zipper noise.
        if (st_r.smooth_cnt == 5'(SMOOTH_CYCLES - 1)) begin
            st_nxt.smooth_cnt = 5'h00;
            st_nxt.gain_a = step_to(st_r.gain_a, st_r.goal_a);
            st_nxt.gain_b = step_to(st_r.gain_b, st_r.goal_b);
        end else begin
            st_nxt.smooth_cnt = st_r.smooth_cnt + 5'h01;
        end
        if (sample_valid) begin
            st_nxt.mix = sum_ab[SAMPLE_W-1:0];
        end
    end

    // Scale each channel by gain/128 and sum; saturate the result.
    assign prod_a = 32'(chan_a_in) * $signed({25'h0, st_r.gain_a});
    assign prod_b = 32'(chan_b_in) * $signed({25'h0, st_r.gain_b});
    always_comb begin
        sum_ab = (prod_a + prod_b) >>> 7;
        if (sum_ab > 32'sh00007FFF) begin
            sum_ab = 32'sh00007FFF;
        end else if (sum_ab < -32'sh00008000) begin
            sum_ab = -32'sh00008000;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= '0;
            st_r.gain_a <= RESET_LEVEL;
            st_r.gain_b <= RESET_LEVEL;
            st_r.goal_a <= RESET_LEVEL;
            st_r.goal_b <= RESET_LEVEL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mix_out = st_r.mix;
    assign mix_valid = st_r.mix_vld;
    assign gain_a_out = st_r.gain_a;
    assign gain_b_out = st_r.gain_b;
    assign held_level_out = ctrl_bus.held_level;
    assign new_pick_out = ctrl_bus.new_pick;
endmodule
`default_nettype wire

// ==== dyn_mixer_asserts.sv ====
// Port-level assertion checker for the picking dynamics mixer.
`timescale 1ns/10ps
`default_nettype none
module dyn_mixer_asserts
    import dyn_pkg::*;
#(
    parameter int HOLD_CYC = dyn_pkg::HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sample_valid,
    input wire logic [dyn_pkg::LEVEL_W-1:0] input_level,
    input wire logic dyn_enable,
    input wire dyn_pkg::dyn_mode_type dyn_type,
    input wire logic [dyn_pkg::LEVEL_W-1:0] chan_a_volume,
    input wire logic [dyn_pkg::LEVEL_W-1:0] chan_b_volume,
    input wire logic mix_valid,
    input wire logic [dyn_pkg::LEVEL_W-1:0] gain_a_out,
    input wire logic [dyn_pkg::LEVEL_W-1:0] gain_b_out,
    input wire logic [dyn_pkg::LEVEL_W-1:0] held_level_out,
    input wire logic new_pick_out
);
    // One clock domain, so clocking and reset are given once here.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Output sample, pick pulse and held level against their causes.
    AST_MIX_VALID: assert property (sample_valid |=> mix_valid)
        else $error("mix_valid missing after a sample");
    AST_PICK_SRC: assert property (new_pick_out |-> $past(sample_valid))
        else $error("pick pulse without a sample");
    AST_PICK_HELD: assert property (
        new_pick_out |-> held_level_out == $past(input_level))
        else $error("held level is not the onset level");
    // The hold keeps the captured peak from sagging right after a pick.
    AST_HELD_HOLD: assert property (
        new_pick_out |=> (held_level_out >= $past(held_level_out)) [*8])
        else $error("held level fell inside the hold");
    // Gain A moves in unit steps and gain B steps are spaced out, so no audible jumps.
    AST_STEP_A: assert property ($changed(gain_a_out) |->
        gain_a_out + 7'h01 == $past(gain_a_out)
        || gain_a_out == $past(gain_a_out) + 7'h01)
        else $error("gain A stepped more than one unit");
    AST_STEP_GAP: assert property (
        $changed(gain_b_out) |=> $stable(gain_b_out) [*8])
        else $error("gain B steps too close together");
    // The uncontrolled channel stays at its fixed volume.
    AST_FIX_B: assert property (
        dyn_enable && dyn_type == MODE_CHAN_A |-> gain_b_out == chan_b_volume)
        else $error("gain B moved in channel A mode");
    AST_FIX_A: assert property (
        dyn_enable && dyn_type == MODE_CHAN_B |-> gain_a_out == chan_a_volume)
        else $error("gain A moved in channel B mode");
endmodule
bind picking_dynamics_channel_mixer dyn_mixer_asserts #(
    .HOLD_CYC(HOLD_CYC)
) u_asserts (
    .clk, .sys_rst, .sample_valid, .input_level, .dyn_enable, .dyn_type,
    .chan_a_volume, .chan_b_volume, .mix_valid, .gain_a_out, .gain_b_out,
    .held_level_out, .new_pick_out
);
`default_nettype wire

// ==== pick_source.sv ====
// Pickup model: steady envelope level and fixed channel samples.
`timescale 1ns/10ps
`default_nettype none
module pick_source (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [dyn_pkg::LEVEL_W-1:0] level_cmd,
    output logic sample_valid,
    output logic [dyn_pkg::LEVEL_W-1:0] input_level,
    output logic signed [dyn_pkg::SAMPLE_W-1:0] chan_a_in,
    output logic signed [dyn_pkg::SAMPLE_W-1:0] chan_b_in
);
    import dyn_pkg::*;
    logic [1:0] phase_r;
    // One sample in four clocks; level and audio change only with it.
    always_ff @(posedge clk) begin
        phase_r <= sys_rst ? 2'h0 : phase_r + 2'h1;
        sample_valid <= !sys_rst && phase_r == 2'h3;
        if (sys_rst || phase_r == 2'h3) begin
            input_level <= level_cmd;
        end
        chan_a_in <= 16'sh03E8;
        chan_b_in <= -16'sh01F4;
    end
endmodule
`default_nettype wire

// ==== picking_dynamics_channel_mixer_bench.sv ====
// Self-checking bench for the picking dynamics mixer.
`timescale 1ns/10ps
`default_nettype none
module picking_dynamics_channel_mixer_bench;
    import dyn_pkg::*;
    logic clk, sys_rst, dyn_enable, sample_valid, mix_valid, new_pick_out;
    logic [LEVEL_W-1:0] input_level, level_cmd, static_chan_balance;
    logic [LEVEL_W-1:0] chan_a_volume, chan_b_volume, release_rate;
    logic [LEVEL_W-1:0] soft_level, loud_level, soft_balance, loud_balance;
    logic [LEVEL_W-1:0] low_threshold, high_threshold, held_level_out;
    logic [LEVEL_W-1:0] gain_a_out, gain_b_out, g;
    logic [LEVEL_W-1:0] lv [3] = '{7'h0A, 7'h1E, 7'h50};
    logic signed [SAMPLE_W-1:0] chan_a_in, chan_b_in, mix_out;
    dyn_mode_type dyn_type;
    int mismatches = 0, num_checks = 0, cycles = 0, n;

    pick_source u_src (.clk, .sys_rst, .level_cmd, .sample_valid,
        .input_level, .chan_a_in, .chan_b_in);
    // A short hold keeps each pick quick to settle.
    picking_dynamics_channel_mixer #(.HOLD_CYC(16)) uut (.clk, .sys_rst,
        .sample_valid, .input_level, .chan_a_in, .chan_b_in, .dyn_enable,
        .dyn_type, .static_chan_balance, .chan_a_volume, .chan_b_volume,
        .soft_level, .soft_balance, .loud_level, .loud_balance,
        .low_threshold, .high_threshold, .release_rate, .mix_out,
        .mix_valid, .gain_a_out, .gain_b_out, .held_level_out, .new_pick_out);

    // Clock at 40 MHz.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A run far past the expected 23k cycles is taken as a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            complete_run();
        end
    end

    // Settings only change under reset, so no goal is ever mid-update.
    task automatic do_reset(input logic en, input dyn_mode_type m);
        @(posedge clk);
        sys_rst <= 1'b1;
        dyn_enable <= en;
        dyn_type <= m;
        level_cmd <= 7'h00;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // Ideal linear curve between thresholds 20 and 60.
    function automatic logic [6:0] expv(input int h, input int s, input int l);
        if (h <= 20)
            return 7'(s);
        if (h >= 60)
            return 7'(l);
        return 7'(s + (l - s) * (h - 20) / 40);
    endfunction

    // Picks, checks the captured peak, then the settled gains.
    task automatic pick(input logic [6:0] lev, input logic [6:0] ea,
        input logic [6:0] eb);
        @(posedge clk);
        level_cmd <= lev;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (new_pick_out !== 1'b1 && n < 40);
        check(new_pick_out, 16'h0001);
        check(held_level_out, lev);
        repeat (1800) @(posedge clk);
        @(negedge clk);
        check(gain_a_out, ea);
        check(gain_b_out, eb);
    endtask

    initial begin
        sys_rst = 1'b1;
        dyn_enable = 1'b1;
        dyn_type = MODE_CHAN_A;
        level_cmd = 7'h00;
        soft_level = 7'h0A;
        loud_level = 7'h5A;
        soft_balance = 7'h46;
        loud_balance = 7'h1E;
        low_threshold = 7'h14;
        high_threshold = 7'h3C;
        release_rate = 7'h64;
        static_chan_balance = 7'h19;
        chan_a_volume = 7'h64;
        chan_b_volume = 7'h64;
        for (int m = 0; m < 3; m++) begin
            do_reset(1'b1, dyn_mode_type'(m));
            for (int i = 0; i < 3; i++) begin
                g = expv(lv[i], m == 2 ? 70 : 10, m == 2 ? 30 : 90);
                if (m == 0)
                    pick(lv[i], g, 7'h64);
                else if (m == 1)
                    pick(lv[i], 7'h64, g);
                else
                    pick(lv[i], 7'h64 - g, g);
            end
        end
        // Falling input: after the hold the peak decays down to the live
        // level and stops there; at the fastest release this takes 4.5k
        // cycles, whereas the slowest release would not have moved at all.
        @(posedge clk);
        level_cmd <= 7'h0A;
        repeat (5000) @(posedge clk);
        @(negedge clk);
        check(held_level_out, 7'h0A);
        check(gain_a_out, 7'h1E);
        check(gain_b_out, 7'h46);
        do_reset(1'b0, MODE_BALANCE);
        repeat (1800) @(posedge clk);
        @(negedge clk);
        check(gain_a_out, 7'h4B);
        check(gain_b_out, 7'h19);
        n = 0;
        while (mix_valid !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        check(mix_out, 16'h01E8);
        complete_run();
    end
endmodule
`default_nettype wire
